// ==== core/pdc_top.sv ====
// Port direction control: direction registers, pin drivers, port 3 events
`timescale 1ns/10ps
`default_nettype none
module pdc_top (
    // System
    input  wire logic                          clock,
    input  wire logic                          sys_rst,
    // Processor write/read access
    input  wire pdc_pkg::pdc_wr_t              cpu_wr,
    input  wire logic [pdc_pkg::IDX_W-1:0]     rd_index,
    output logic      [7:0]                    rd_data,
    // Output latches and pull-up option from the port block
    input  wire logic [pdc_pkg::NUM_PORTS*8-1:0] out_latch,
    input  wire logic [pdc_pkg::PORT_PULLUP_GROUPS-1:0] pullup_option_register,
    // Pin drive, output enable active low
    output logic      [pdc_pkg::NUM_PORTS*8-1:0] pin_out,
    output logic      [pdc_pkg::NUM_PORTS*8-1:0] pin_oe_n,
    output logic      [pdc_pkg::NUM_PORTS*8-1:0] pullup_en,
    // Interrupt request pulses caused by port 3 output changes
    output logic      [pdc_pkg::NUM_EXT_IRQ-1:0] ext_irq_set
);
    import pdc_pkg::*;

    logic [7:0] port_direction [NUM_PORTS];
    logic [NUM_EXT_IRQ-1:0] p3_prev;
    logic [NUM_EXT_IRQ-1:0] next_p3_prev;
    logic [NUM_EXT_IRQ-1:0] next_irq;

    // Shared by the write select and the read mux
    function automatic logic idx_hit(input logic [IDX_W-1:0] index,
                                     input int               p);
        return index == IDX_W'(p);
    endfunction : idx_hit

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_reg
        pdc_reg_byte u_reg (
            .clock   (clock),
            .sys_rst (sys_rst),
            .sel     (cpu_wr.wr && idx_hit(cpu_wr.index, p)),
            .bit_op  (cpu_wr.bit_op),
            .bit_sel (cpu_wr.bit_sel),
            .data    (cpu_wr.data),
            .value   (port_direction[p])
        );
    end

    // Unmapped indices read as all ones, like an idle input port
    always_comb begin
        rd_data = 8'hff;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (idx_hit(rd_index, p)) begin
                rd_data = port_direction[p];
            end
        end
    end

    // Pin drivers are plain gating, so a mode change acts at once
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int b = 0; b < 8; b++) begin
                pin_oe_n[p*8+b]  = port_direction[p][b];
                pin_out[p*8+b]   = out_latch[p*8+b] & ~port_direction[p][b];
                pullup_en[p*8+b] = pullup_option_register[p]
                                   & port_direction[p][b];
            end
        end
    end

    // The output latch reaches the interrupt edge detector, so any latch change
    // on an output pin among port 3 bits 0 to 2 raises a request; software must mask it beforehand.
    always_comb begin
        next_p3_prev = p3_prev;
        next_irq     = '0;
        for (int i = 0; i < NUM_EXT_IRQ; i++) begin
            next_p3_prev[i] = out_latch[PORT_EXT_IRQ*8+i];
            next_irq[i] = ~port_direction[PORT_EXT_IRQ][i]
                          & (out_latch[PORT_EXT_IRQ*8+i] != p3_prev[i]);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            p3_prev     <= '0;
            ext_irq_set <= '0;
        end else begin
            p3_prev     <= next_p3_prev;
            ext_irq_set <= next_irq;
        end
    end

    a_reset_input: assert property (@(posedge clock)
        $fell(sys_rst) |-> port_direction[0] == 8'hff)
        else $error("direction not all ones after reset");

    a_byte_write: assert property (@(posedge clock)
        disable iff (sys_rst)
        cpu_wr.wr && !cpu_wr.bit_op && cpu_wr.index == 3'h1
        |=> port_direction[1] == $past(cpu_wr.data))
        else $error("byte write not stored");

    a_bit_write: assert property (@(posedge clock)
        disable iff (sys_rst)
        cpu_wr.wr && cpu_wr.bit_op && cpu_wr.index == 3'h0
        |=> port_direction[0][$past(cpu_wr.bit_sel)] == $past(cpu_wr.data[0]))
        else $error("bit write not stored");

    a_driver_off: assert property (@(posedge clock)
        disable iff (sys_rst)
        port_direction[4][2] |-> pin_oe_n[34] && !pin_out[34])
        else $error("input pin still driven");

    a_driver_on: assert property (@(posedge clock)
        disable iff (sys_rst)
        !port_direction[5][0] |-> !pin_oe_n[40]
        && pin_out[40] == out_latch[40])
        else $error("output pin not driving latch");

    a_pullup_gate: assert property (@(posedge clock)
        disable iff (sys_rst)
        pullup_en[8] |-> port_direction[1][0] && pullup_option_register[1])
        else $error("pull-up on while output");

    a_p3_irq_raise: assert property (@(posedge clock)
        disable iff (sys_rst)
        !port_direction[3][0] && $changed(out_latch[24])
        && !$past(sys_rst) |=> ext_irq_set[0])
        else $error("port 3 change missed");

    a_p3_irq_quiet: assert property (@(posedge clock)
        disable iff (sys_rst)
        ext_irq_set[1] |-> $past(!port_direction[3][1]))
        else $error("spurious port 3 request");

    // A pin left as input never raises a request, whatever its latch does
    a_p3_input_quiet: assert property (@(posedge clock)
        disable iff (sys_rst)
        port_direction[3][2] |=> !ext_irq_set[2])
        else $error("request from input pin");

    a_p3_steady_quiet: assert property (@(posedge clock)
        disable iff (sys_rst)
        $stable(out_latch[24]) && !$past(sys_rst) |=> !ext_irq_set[0])
        else $error("request without level change");

    a_reset_pins: assert property (@(posedge clock)
        sys_rst |-> &pin_oe_n && pin_out == '0 && ext_irq_set == '0)
        else $error("pins not released during reset");

    a_reset_port5: assert property (@(posedge clock)
        $fell(sys_rst) |-> port_direction[5] == 8'hff)
        else $error("port 5 not input after reset");

    a_rd_unmapped: assert property (@(posedge clock)
        disable iff (sys_rst)
        rd_index > 3'h5 |-> rd_data == 8'hff)
        else $error("unmapped read not all ones");

    a_rd_mapped: assert property (@(posedge clock)
        disable iff (sys_rst)
        rd_index == 3'h3 |-> rd_data == port_direction[3])
        else $error("read mux wrong register");

    a_bit_others: assert property (@(posedge clock)
        disable iff (sys_rst)
        cpu_wr.wr && cpu_wr.bit_op && cpu_wr.index == 3'h0
        && cpu_wr.bit_sel == 3'h1
        |=> port_direction[0][7:2] == $past(port_direction[0][7:2])
        && port_direction[0][0] == $past(port_direction[0][0]))
        else $error("bit write touched other bits");

    a_no_write_hold: assert property (@(posedge clock)
        disable iff (sys_rst)
        !cpu_wr.wr |=> $stable(port_direction[2]))
        else $error("register changed without write");

    a_idx_ignored: assert property (@(posedge clock)
        disable iff (sys_rst)
        cpu_wr.wr && cpu_wr.index > 3'h5 |=> $stable(port_direction[0]))
        else $error("unmapped write landed");

    a_byte_write_p5: assert property (@(posedge clock)
        disable iff (sys_rst)
        cpu_wr.wr && !cpu_wr.bit_op && cpu_wr.index == 3'h5
        |=> port_direction[5] == $past(cpu_wr.data))
        else $error("port 5 byte write not stored");

    a_oe_port0: assert property (@(posedge clock)
        disable iff (sys_rst)
        pin_oe_n[7:0] == port_direction[0])
        else $error("port 0 enables wrong");

    a_oe_port2: assert property (@(posedge clock)
        disable iff (sys_rst)
        pin_oe_n[23:16] == port_direction[2])
        else $error("port 2 enables wrong");

    a_oe_port5: assert property (@(posedge clock)
        disable iff (sys_rst)
        pin_oe_n[47:40] == port_direction[5])
        else $error("port 5 enables wrong");

    a_out_port1: assert property (@(posedge clock)
        disable iff (sys_rst)
        pin_out[15:8] == (out_latch[15:8] & ~port_direction[1]))
        else $error("port 1 drive wrong");

    a_out_port4: assert property (@(posedge clock)
        disable iff (sys_rst)
        pin_out[39:32] == (out_latch[39:32] & ~port_direction[4]))
        else $error("port 4 drive wrong");

    a_pullup_p0: assert property (@(posedge clock)
        disable iff (sys_rst)
        pullup_en[7:0] ==
        (pullup_option_register[0] ? port_direction[0] : 8'h00))
        else $error("port 0 pull-up wrong");

    a_pullup_p5: assert property (@(posedge clock)
        disable iff (sys_rst)
        pullup_en[47:40] ==
        (pullup_option_register[5] ? port_direction[5] : 8'h00))
        else $error("port 5 pull-up wrong");
endmodule : pdc_top
`default_nettype wire

// ==== core/pdc_pkg.sv ====
// Package: port direction control constants and carrier types
package pdc_pkg;
    localparam int NUM_PORTS          = 6;
    localparam int PORT_W             = 8;
    localparam int IDX_W              = 3;
    localparam logic [7:0] DIR_RESET  = 8'hff;
    localparam int NUM_EXT_IRQ        = 3;
    localparam int PORT_EXT_IRQ       = 3;
    localparam int PORT_PULLUP_GROUPS = 6;

    // Processor write request: byte or single-bit write to one register
    typedef struct packed {
        logic             wr;
        logic             bit_op;
        logic [IDX_W-1:0] index;
        logic [2:0]       bit_sel;
        logic [7:0]       data;
    } pdc_wr_t;
endpackage : pdc_pkg

// ==== core/pdc_reg_byte.sv ====
// One direction register with byte and single-bit write
`timescale 1ns/10ps
`default_nettype none
module pdc_reg_byte (
    // System
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Write port
    input  wire logic       sel,
    input  wire logic       bit_op,
    input  wire logic [2:0] bit_sel,
    input  wire logic [7:0] data,
    // Contents
    output logic      [7:0] value
);
    import pdc_pkg::*;

    logic [7:0] next_value;

    always_comb begin
        next_value = value;
        if (sel) begin
            if (bit_op) begin
                next_value[bit_sel] = data[0];
            end else begin
                next_value = data;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            value <= DIR_RESET;
        end else begin
            value <= next_value;
        end
    end
endmodule : pdc_reg_byte
`default_nettype wire

// ==== dv/port_direction_control_tb.sv ====
// Self-checking testbench for port direction control
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
 $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module port_direction_control_tb;
    import pdc_pkg::*;
    logic          clock;
    logic          sys_rst;
    pdc_wr_t       cpu_wr;
    logic [2:0]    rd_index;
    logic [7:0]    rd_data;
    logic [47:0]   out_latch;
    logic [5:0]    pull_opt;
    logic [47:0]   pin_out;
    logic [47:0]   pin_oe_n;
    logic [47:0]   pullup_en;
    logic [2:0]    ext_irq_set;
    int            mismatches = 0;
    int            checks_done = 0;
    int            cycles = 0;
    pdc_top DUT (.clock(clock), .sys_rst(sys_rst), .cpu_wr(cpu_wr),
        .rd_index(rd_index), .rd_data(rd_data), .out_latch(out_latch),
        .pullup_option_register(pull_opt), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
        .ext_irq_set(ext_irq_set));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // One write taken at the rising edge between two falling edges
    task automatic wr(input logic [2:0] i, input logic b,
                      input logic [2:0] s, input logic [7:0] d);
        @(negedge clock) cpu_wr = '{1'b1, b, i, s, d};
        @(negedge clock) cpu_wr.wr = 1'b0;
    endtask : wr
    task automatic t_reset;
        for (int i = 0; i < 8; i++) begin
            rd_index = 3'(i);
            #1 `CHK(rd_data, 8'hff)
        end
        `CHK(pin_oe_n, {48{1'b1}})
    endtask : t_reset
    task automatic t_bytes;
        wr(3'h0, 1'b0, 3'h0, 8'h5a);
        wr(3'h3, 1'b0, 3'h0, 8'hfe);
        wr(3'h1, 1'b0, 3'h0, 8'hc3);
        wr(3'h2, 1'b0, 3'h0, 8'hfb);
        `CHK(pin_oe_n, {16'hffff, 8'hfe, 8'hfb, 8'hc3, 8'h5a})
        wr(3'h0, 1'b1, 3'h1, 8'hfe);
        rd_index = 3'h0;
        #1 `CHK(rd_data, 8'h58)
        wr(3'h6, 1'b0, 3'h0, 8'h00);
        rd_index = 3'h6;
        #1 `CHK(rd_data, 8'hff)
        `CHK(pin_oe_n[7:0], 8'h58)
        wr(3'h5, 1'b1, 3'h0, 8'h00);
        `CHK({pin_oe_n[40], pin_out[40]}, 2'b00)
        `CHK(pin_oe_n[39:32], 8'hff)
        out_latch[40] = 1'b1;
        #1 `CHK(pin_out[40], 1'b1)
    endtask : t_bytes
    task automatic t_irq;
        // Pin 24 drives, pin 25 is an input, so only one request
        out_latch[25] = 1'b1;
        @(negedge clock) `CHK(ext_irq_set, 3'b000)
        out_latch[24] = 1'b1;
        @(negedge clock) `CHK(ext_irq_set, 3'b001)
        `CHK(pin_out[25:24], 2'b01)
        @(negedge clock) `CHK(ext_irq_set, 3'b000)
    endtask : t_irq
    task automatic t_pullup;
        pull_opt = 6'h01;
        #1 `CHK(pullup_en, {40'h0, 8'h58})
        pull_opt = 6'h02;
        #1 `CHK(pullup_en, {32'h0, 8'hc3, 8'h0})
        pull_opt = 6'h08;
        #1 `CHK(pullup_en, {16'h0, 8'hfe, 24'h0})
        sys_rst = 1'b1;
        rd_index = 3'h3;
        #1 `CHK(rd_data, 8'hff)
    endtask : t_pullup
    always @(posedge clock) begin
        cycles++;
        if (cycles == 500) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        sys_rst = 1'b1;
        cpu_wr = '0;
        rd_index = 3'h0;
        out_latch = '0;
        pull_opt = '0;
        repeat (3) @(negedge clock);
        t_reset();
        sys_rst = 1'b0;
        t_bytes();
        @(negedge clock) t_irq();
        t_pullup();
        print_verdict();
    end
endmodule : port_direction_control_tb
`default_nettype wire
